//--- intc_one_pkg.sv
package intc_one_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;
endpackage

//--- intc_one_regs.svh
`ifndef INTC_ONE_REGS_SVH
`define INTC_ONE_REGS_SVH
// Register byte addresses on the Avalon-MM slave.
`define ICO_OFFS_CTRL 4'h0
`define ICO_OFFS_STAT 4'h4
`define ICO_OFFS_MASK 4'h8
`define ICO_OFFS_GLOB 4'hc
// Bit positions inside the control register.
`define ICO_BIT_TIMEBASE0_REQUEST_FLAG 7
`define ICO_BIT_ADF 6
`define ICO_BIT_MULTIFUNC_GROUP2_REQUEST_FLAG 5
`define ICO_BIT_MULTIFUNC_GROUP1_REQUEST_FLAG 4
`define ICO_BIT_TIMEBASE0_IRQ_ENABLE 3
`define ICO_BIT_ADE 2
`define ICO_BIT_MULTIFUNC_GROUP2_IRQ_ENABLE 1
`define ICO_BIT_MULTIFUNC_GROUP1_IRQ_ENABLE 0
`define ICO_CTRL_RESET 8'h00
`define ICO_EVT_RESET 4'h0
`endif

//--- interrupt_control_register_one.sv
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "intc_one_regs.svh"

// What this block does
// - Bit 7 is time base 0 request flag.
// - Converter flag bit 6, enable bit 2, optional.
// - Bit 5 is group 2 request flag.
// - Bit 3 enables time base 0 interrupt.
// - Bit 1 enables group 2 interrupt.
// - Bits 4/0 group 1 only with timer 2.
// - Event sets flag; request needs enable too.
// - Global enable low suppresses the four request outputs; irq is not gated by it.
module interrupt_control_register_one #(
  parameter bit HAS_CONVERTER = 1'b1,
  parameter bit HAS_GROUP1 = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic timebase0_event,
  input wire logic conversion_event,
  input wire logic multifunc_group2_event,
  input wire logic multifunc_group1_event,
  output logic timebase0_irq_req,
  output logic conversion_irq_req,
  output logic multifunc_group2_irq_req,
  output logic multifunc_group1_irq_req,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Implemented-bit mask of the control register, set by the variant.
  localparam logic [7:0] IMPL_MASK = {1'b1, HAS_CONVERTER, 1'b1, HAS_GROUP1,
                                      1'b1, HAS_CONVERTER, 1'b1, HAS_GROUP1};

  // Maps the four event inputs onto their flag positions.
  function automatic logic [7:0] flag_vec(input logic [3:0] ev);
    flag_vec = 8'h00;
    flag_vec[`ICO_BIT_TIMEBASE0_REQUEST_FLAG] = ev[3];
    flag_vec[`ICO_BIT_ADF] = ev[2];
    flag_vec[`ICO_BIT_MULTIFUNC_GROUP2_REQUEST_FLAG] = ev[1];
    flag_vec[`ICO_BIT_MULTIFUNC_GROUP1_REQUEST_FLAG] = ev[0];
  endfunction

  intc_one_pkg::bus_state_t bus_reg, bus_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [3:0] stat_reg, stat_next;
  logic [3:0] mask_reg, mask_next;
  logic glob_reg, glob_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [3:0] events;
  logic [3:0] req_vec;
  logic wr_hit;

  assign events = {timebase0_event, conversion_event, multifunc_group2_event, multifunc_group1_event};
  // A write lands at the edge where waitrequest is low, the same edge at which the master lets go.
  assign wr_hit = (bus_reg == intc_one_pkg::BUS_ANSWER) && clk_en && avs_write && avs_byteenable[0];

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: each access answers one clock-enabled cycle after it is presented.
  always_comb
  begin
    bus_next = bus_reg;
    rdata_next = rdata_reg;
    case (bus_reg)
      intc_one_pkg::BUS_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          bus_next = intc_one_pkg::BUS_ANSWER;
        end
        if (avs_read)
        begin
          if (avs_address == `ICO_OFFS_CTRL)
          begin
            rdata_next = {24'h000000, ctrl_reg};
          end
          else if (avs_address == `ICO_OFFS_STAT)
          begin
            rdata_next = {28'h0000000, stat_reg};
          end
          else if (avs_address == `ICO_OFFS_MASK)
          begin
            rdata_next = {28'h0000000, mask_reg};
          end
          else if (avs_address == `ICO_OFFS_GLOB)
          begin
            rdata_next = {31'h00000000, glob_reg};
          end
          else
          begin
            rdata_next = 32'h00000000;
          end
        end
      end
      default:
      begin
        bus_next = intc_one_pkg::BUS_IDLE;
      end
    endcase
  end

  // A frozen slave keeps the master waiting, so no access can slip past a stopped clock enable.
  assign avs_waitrequest = (avs_read || avs_write) && !((bus_reg == intc_one_pkg::BUS_ANSWER) && clk_en);
  assign avs_readdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register state; hardware set wins over a software clear.
  always_comb
  begin
    ctrl_next = ctrl_reg;
    stat_next = stat_reg;
    mask_next = mask_reg;
    glob_next = glob_reg;
    if (wr_hit && avs_address == `ICO_OFFS_CTRL)
    begin
      ctrl_next = avs_writedata[7:0];
    end
    if (wr_hit && avs_address == `ICO_OFFS_STAT)
    begin
      stat_next = stat_reg & ~avs_writedata[3:0];
    end
    if (wr_hit && avs_address == `ICO_OFFS_MASK)
    begin
      mask_next = avs_writedata[3:0];
    end
    if (wr_hit && avs_address == `ICO_OFFS_GLOB)
    begin
      glob_next = avs_writedata[0];
    end
    ctrl_next = (ctrl_next | flag_vec(events)) & IMPL_MASK;
    stat_next = stat_next | (events & {1'b1, HAS_CONVERTER, 1'b1, HAS_GROUP1});
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bus_reg <= intc_one_pkg::BUS_IDLE;
      rdata_reg <= 32'h00000000;
      ctrl_reg <= `ICO_CTRL_RESET;
      stat_reg <= `ICO_EVT_RESET;
      mask_reg <= `ICO_EVT_RESET;
      glob_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      bus_reg <= bus_next;
      rdata_reg <= rdata_next;
      ctrl_reg <= ctrl_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      glob_reg <= glob_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Requests toward the vectoring logic.
  assign req_vec[3] = ctrl_reg[`ICO_BIT_TIMEBASE0_REQUEST_FLAG] & ctrl_reg[`ICO_BIT_TIMEBASE0_IRQ_ENABLE];
  assign req_vec[2] = ctrl_reg[`ICO_BIT_ADF] & ctrl_reg[`ICO_BIT_ADE];
  assign req_vec[1] = ctrl_reg[`ICO_BIT_MULTIFUNC_GROUP2_REQUEST_FLAG] & ctrl_reg[`ICO_BIT_MULTIFUNC_GROUP2_IRQ_ENABLE];
  assign req_vec[0] = ctrl_reg[`ICO_BIT_MULTIFUNC_GROUP1_REQUEST_FLAG] & ctrl_reg[`ICO_BIT_MULTIFUNC_GROUP1_IRQ_ENABLE];
  assign timebase0_irq_req = glob_reg & req_vec[3];
  assign conversion_irq_req = glob_reg & req_vec[2];
  assign multifunc_group2_irq_req = glob_reg & req_vec[1];
  assign multifunc_group1_irq_req = glob_reg & req_vec[0];
  assign irq = |(stat_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Sequences shared by the checks below.
  sequence ev_tb0;
    clk_en && timebase0_event;
  endsequence

  sequence ev_conv;
    clk_en && conversion_event;
  endsequence

  sequence ev_mf2;
    clk_en && multifunc_group2_event;
  endsequence

  sequence ev_mf1;
    clk_en && multifunc_group1_event;
  endsequence

  sequence bus_taken;
    clk_en && (avs_read || avs_write) && bus_reg == intc_one_pkg::BUS_IDLE;
  endsequence

  sequence bus_next_edge;
    bus_taken ##1 clk_en;
  endsequence

  sequence frozen;
    !clk_en;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Event flags: an event seen on a running edge shows in the next cycle.
  AST_TB0_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n) ev_tb0 |=> ctrl_reg[7])
    else $error("time base 0 flag not set after event");

  AST_CONV_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
    ev_conv |=> ctrl_reg[6] == HAS_CONVERTER)
    else $error("converter flag does not follow its event");

  AST_MF2_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n) ev_mf2 |=> ctrl_reg[5])
    else $error("group 2 flag not set after event");

  AST_MF1_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
    ev_mf1 |=> ctrl_reg[4] == HAS_GROUP1)
    else $error("group 1 flag does not follow its event");

  AST_TB0_STAT_SET: assert property (@(posedge clk) disable iff (!rst_n) ev_tb0 |=> stat_reg[3])
    else $error("time base 0 status not set after event");

  AST_MF2_STAT_SET: assert property (@(posedge clk) disable iff (!rst_n) ev_mf2 |=> stat_reg[1])
    else $error("group 2 status not set after event");

  ////////////////////////////////////////////////////////////////////////////
  // Variant bits: control bits the variant leaves out always read zero.
  AST_UNIMPL_ZERO: assert property (@(posedge clk) disable iff (!rst_n) (ctrl_reg & ~IMPL_MASK) == 8'h00)
    else $error("unimplemented control bit set");

  AST_CONV_ABSENT: assert property (@(posedge clk) disable iff (!rst_n)
    !HAS_CONVERTER |-> !ctrl_reg[6] && !ctrl_reg[2])
    else $error("converter bits set on a variant without it");

  AST_GROUP1_ABSENT: assert property (@(posedge clk) disable iff (!rst_n)
    !HAS_GROUP1 |-> !ctrl_reg[4] && !ctrl_reg[0])
    else $error("group 1 bits set on a variant without it");

  ////////////////////////////////////////////////////////////////////////////
  // Requests: flag, enable and global enable must all be set.
  AST_TB0_NEEDS_EN: assert property (@(posedge clk) disable iff (!rst_n) timebase0_irq_req |-> ctrl_reg[3])
    else $error("time base 0 request without enable");

  AST_CONV_NEEDS_EN: assert property (@(posedge clk) disable iff (!rst_n)
    conversion_irq_req |-> ctrl_reg[6] && ctrl_reg[2])
    else $error("converter request without flag and enable");

  AST_MF2_NEEDS_EN: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_reg[5] && glob_reg |-> multifunc_group2_irq_req == ctrl_reg[1])
    else $error("group 2 request does not follow its enable");

  AST_MF1_NEEDS_EN: assert property (@(posedge clk) disable iff (!rst_n)
    multifunc_group1_irq_req |-> ctrl_reg[4] && ctrl_reg[0])
    else $error("group 1 request without flag and enable");

  AST_FLAG_NO_EN: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_reg[7] && !ctrl_reg[3] |-> !timebase0_irq_req)
    else $error("request raised with enable clear");

  AST_FLAG_WITH_EN: assert property (@(posedge clk) disable iff (!rst_n)
    glob_reg && ctrl_reg[7] && ctrl_reg[3] |-> timebase0_irq_req)
    else $error("request missing with flag and enable set");

  AST_GLOBAL_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    !glob_reg |-> !(timebase0_irq_req || conversion_irq_req || multifunc_group2_irq_req || multifunc_group1_irq_req))
    else $error("request raised with global enable clear");

  ////////////////////////////////////////////////////////////////////////////
  // Reset, clock enable and the register bus.
  AST_RESET_CLEAR: assert property (@(posedge clk)
    !rst_n |=> ctrl_reg == 8'h00 && stat_reg == 4'h0 && !glob_reg)
    else $error("registers not cleared by reset");

  AST_FREEZE: assert property (@(posedge clk) disable iff (!rst_n)
    frozen |=> $stable(ctrl_reg) && $stable(stat_reg))
    else $error("state changed while the clock enable was low");

  AST_BUS_WAIT: assert property (@(posedge clk) disable iff (!rst_n) bus_taken |-> avs_waitrequest)
    else $error("request answered without a wait state");

  AST_BUS_ANSWER: assert property (@(posedge clk) disable iff (!rst_n)
    bus_next_edge |-> !avs_waitrequest && bus_reg == intc_one_pkg::BUS_ANSWER)
    else $error("request not answered in the next cycle");

  AST_IDLE_NO_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
    !avs_read && !avs_write |-> !avs_waitrequest)
    else $error("waitrequest high with no request");

endmodule

//--- tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_fail++; $display("unexpected %s exp %h got %h", n, e, a); end end
module tb;
  logic clk = 1'b0, rst_n = 1'b0, rd_req, wr, wq, irq;
  logic clk_en = 1'b1;
  logic [3:0] adr = 4'h0, ev = 4'h0, req;
  logic [31:0] wd = 32'h0, rdat;
  logic [7:0] q;
  int n_fail = 0, checked = 0;
  always #10 clk = ~clk;
  interrupt_control_register_one interrupt_control_register_one_inst (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .avs_address(adr), .avs_read(rd_req), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'h1),
    .avs_readdata(rdat), .avs_waitrequest(wq), .timebase0_event(ev[3]), .conversion_event(ev[2]),
    .multifunc_group2_event(ev[1]), .multifunc_group1_event(ev[0]), .timebase0_irq_req(req[3]),
    .conversion_irq_req(req[2]), .multifunc_group2_irq_req(req[1]), .multifunc_group1_irq_req(req[0]), .irq(irq));
  initial
  begin
    rd_req = 1'b0;
    wr = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One Avalon access; the request is held until waitrequest is seen low at an edge.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wr <= w;
    rd_req <= !w;
    adr <= a;
    wd <= {24'h0, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wq !== 1'b0 && n < 50);
    if (wq !== 1'b0)
    begin
      n_fail++;
      finish_test;
    end
    q = rdat[7:0];
    wr <= 1'b0;
    rd_req <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    bus(1'b0, a, 8'h0);
    `CHK(n, e, q)
  endtask
  task automatic pulse(input logic [3:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 4'h0;
    @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(4'h0, 8'h00, "control");
    rd(4'h4, 8'h00, "status");
    rd(4'h8, 8'h00, "mask");
    @(negedge clk);
    `CHK("irq", 1'b0, irq)
    $display("test reset done");
  endtask
  task automatic t_rw;
    bus(1'b1, 4'h0, 8'ha5);
    rd(4'h0, 8'ha5, "control");
    bus(1'b1, 4'h0, 8'h5a);
    rd(4'h0, 8'h5a, "control");
    rd(4'h2, 8'h00, "unmapped");
    bus(1'b1, 4'h0, 8'h00);
    $display("test rw done");
  endtask
  task automatic t_enable;
    bus(1'b1, 4'h0, 8'h0f);
    pulse(4'hf);
    rd(4'h0, 8'hff, "flags");
    `CHK("req global off", 4'h0, req)
    bus(1'b1, 4'hc, 8'h01);
    @(negedge clk);
    `CHK("req global on", 4'hf, req)
    bus(1'b1, 4'h0, 8'hf0);
    @(negedge clk);
    `CHK("req enables off", 4'h0, req)
    bus(1'b1, 4'h0, 8'h2a);
    @(negedge clk);
    `CHK("req group2", 4'h2, req)
    $display("test enable done");
  endtask
  task automatic t_irq;
    rd(4'h4, 8'h0f, "status");
    `CHK("irq masked", 1'b0, irq)
    bus(1'b1, 4'h8, 8'h01);
    @(negedge clk);
    `CHK("irq unmasked", 1'b1, irq)
    bus(1'b1, 4'h4, 8'h01);
    @(negedge clk);
    `CHK("irq cleared", 1'b0, irq)
    rd(4'h4, 8'h0e, "status");
    $display("test irq done");
  endtask
  task automatic t_freeze;
    @(posedge clk);
    clk_en <= 1'b0;
    pulse(4'h8);
    @(posedge clk);
    clk_en <= 1'b1;
    rd(4'h0, 8'h2a, "frozen flags");
    pulse(4'h8);
    rd(4'h0, 8'haa, "running flags");
    $display("test freeze done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_rw;
    t_enable;
    t_irq;
    t_freeze;
    finish_test;
  end
  initial
  begin
    repeat (2000) @(posedge clk);
    n_fail++;
    finish_test;
  end
endmodule
